/* rtl/tec_pkg.sv */
// Purpose: Shared constants and types for the 8-bit timer/event counter.
// Assumes: fx is the block clock; register accesses are synchronous byte or bit writes.
// Notes: Field layouts mirror the mode and direction registers bit for bit.
//
// Notes on behaviour
// - Count compared to match value; equality requests interrupt
// - Match value takes any byte, zero included
// - Reset leaves match value untouched
// - Count readable, reset clears it to zero
// - Mode register resets zero; bit or byte writes
// - Run bit low stops and zeroes counter
// - Select field: fx, fx/32, rising, falling edge
// - Output enable drives timer output onto pin
// - No timer output with external edge source
// - Match value written while running acts immediately
// - Direction resets ones; upper nibble fixed one
// - Interval one to 256 count clocks
// - External pin pulses can be counted
// - One square-wave output set by match value
// - On match counter wraps to zero, requests interrupt
// - Match toggles output; stopping forces it low
// - Each valid external edge adds one
package tec_pkg;
    localparam int TEC_ADDR_W = 16;
    localparam logic [15:0] TEC_ADDR_PORT5_DIR = 16'hFF25;
    localparam logic [15:0] TEC_ADDR_MODE = 16'hFF53;
    localparam logic [15:0] TEC_ADDR_COUNT = 16'hFF50;
    localparam logic [15:0] TEC_ADDR_MATCH = 16'hFF51;

    localparam int TEC_MODE_RUN_BIT = 7;
    localparam int TEC_MODE_SEL_HI_BIT = 2;
    localparam int TEC_MODE_SEL_LO_BIT = 1;
    localparam int TEC_MODE_OE_BIT = 0;
    localparam int TEC_DIR_PIN_BIT = 0;

    localparam logic [7:0] TEC_MODE_RESET = 8'h00;
    localparam logic [7:0] TEC_MODE_WRITABLE = 8'h87;
    localparam logic [7:0] TEC_DIR_RESET = 8'hFF;
    localparam logic [7:0] TEC_DIR_FIXED_ONES = 8'hF0;
    localparam logic [7:0] TEC_COUNT_RESET = 8'h00;
    localparam logic [7:0] TEC_UNMAPPED_READ = 8'h00;

    localparam int TEC_FX_HZ = 20_000_000;
    localparam int TEC_FX_PERIOD_NS = 1_000_000_000 / TEC_FX_HZ;
    localparam int TEC_PRESCALE_DIV = 32;
    localparam int TEC_PRESCALE_W = 5;
    localparam logic [4:0] TEC_PRESCALE_LAST = 5'(TEC_PRESCALE_DIV - 1);
    localparam logic [4:0] TEC_PRESCALE_RESET = 5'h00;

    typedef enum logic [1:0] {
        TEC_SEL_FX,
        TEC_SEL_FX32,
        TEC_SEL_RISE,
        TEC_SEL_FALL
    } tec_clk_sel_t;

    typedef struct packed {
        logic run;
        logic [3:0] zero;
        tec_clk_sel_t sel;
        logic out_en;
    } tec_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic [7:0] wmask;
    } tec_reg_req_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } tec_edge_t;

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        tec_edge_t edges;
    } tec_sync_state_t;

    typedef struct packed {
        tec_mode_t mode;
        logic [7:0] dir;
        logic [7:0] count;
        logic [7:0] match;
        logic [4:0] prescale;
        logic wave;
        logic irq;
        logic pin_o;
        logic pin_oe;
        logic [7:0] rdata;
        logic rvalid;
    } tec_state_t;
endpackage

/* rtl/tec_edge_sync.sv */
// Purpose: Two-flop synchroniser with rising and falling edge pulses.
// Assumes: Input may change at any time relative to clk_in.
// Notes: Edge pulses lag the pin by three clocks.
`timescale 1ns/100ps
`default_nettype none
module tec_edge_sync (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic async_in,
    output tec_pkg::tec_edge_t edges_out
);
    import tec_pkg::*;

    tec_sync_state_t st_r;
    tec_sync_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // The first flop feeds only the second one
        st_nxt.meta = async_in;
        st_nxt.sync = st_r.meta;
        st_nxt.last = st_r.sync;
        st_nxt.edges.rise = st_r.sync & ~st_r.last;
        st_nxt.edges.fall = ~st_r.sync & st_r.last;
        // Pipeline keeps tracking the pin in reset, so a pin held high gives no false rise
        if (!rst_b_in) begin
            st_nxt.edges = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        st_r <= st_nxt;
    end

    assign edges_out = st_r.edges;
endmodule
`default_nettype wire

/* rtl/tec_timer.sv */
// Purpose: 8-bit timer/event counter with match interrupt and square-wave pin.
// Assumes: clk_in is fx; the port block supplies the pin output latch bit.
// Notes: Register reads answer one clock after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module tec_timer #(
    parameter int PRESCALE_DIV = tec_pkg::TEC_PRESCALE_DIV
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire tec_pkg::tec_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic shared_pin_in,
    input wire logic port_latch_in,
    output logic shared_pin_out,
    output logic shared_pin_oe_out,
    output logic wave_out,
    output logic match_irq_out,
    output logic [7:0] port5_direction_out
);
    import tec_pkg::*;

    localparam logic [4:0] PRESCALE_LAST = 5'(PRESCALE_DIV - 1);

    tec_state_t st_r;
    tec_state_t st_nxt;
    tec_edge_t ext_edges;

    logic sel_ext;
    logic count_tick;
    logic at_match;
    logic wr_mode;
    logic wr_dir;
    logic wr_match;
    logic timer_owns_pin;
    logic [7:0] mode_bits;
    logic [7:0] mode_merged;
    logic [7:0] dir_merged;

    // Pin edges are only trusted after resynchronisation
    tec_edge_sync u_ext_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .async_in(shared_pin_in),
        .edges_out(ext_edges)
    );

    always_comb begin
        mode_bits = st_r.mode;
        sel_ext = (st_r.mode.sel == TEC_SEL_RISE) || (st_r.mode.sel == TEC_SEL_FALL);
        at_match = (st_r.count == st_r.match);
        wr_mode = reg_req_in.wr && (reg_req_in.addr == TEC_ADDR_MODE);
        wr_dir = reg_req_in.wr && (reg_req_in.addr == TEC_ADDR_PORT5_DIR);
        wr_match = reg_req_in.wr && (reg_req_in.addr == TEC_ADDR_MATCH);
        // Bit writes are byte writes with a single mask bit set
        mode_merged = ((mode_bits & ~reg_req_in.wmask) | (reg_req_in.wdata & reg_req_in.wmask))
            & TEC_MODE_WRITABLE;
        dir_merged = (st_r.dir & ~reg_req_in.wmask) | (reg_req_in.wdata & reg_req_in.wmask)
            | TEC_DIR_FIXED_ONES;
        // Count source selection
        unique case (st_r.mode.sel)
            TEC_SEL_FX: count_tick = st_r.mode.run;
            TEC_SEL_FX32: count_tick = st_r.mode.run && (st_r.prescale == PRESCALE_LAST);
            TEC_SEL_RISE: count_tick = st_r.mode.run && ext_edges.rise;
            TEC_SEL_FALL: count_tick = st_r.mode.run && ext_edges.fall;
        endcase
        // An edge source takes the pin away from the timer output
        timer_owns_pin = st_r.mode.out_en && !sel_ext;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.rvalid = 1'b0;

        // Prescaler only runs while counting, so fx/32 starts from a full period
        if (st_r.mode.run && (st_r.mode.sel == TEC_SEL_FX32)) begin
            if (st_r.prescale == PRESCALE_LAST) begin
                st_nxt.prescale = TEC_PRESCALE_RESET;
            end else begin
                st_nxt.prescale = 5'(st_r.prescale + 5'h01);
            end
        end else begin
            st_nxt.prescale = TEC_PRESCALE_RESET;
        end

        if (!st_r.mode.run) begin
            st_nxt.count = TEC_COUNT_RESET;
            st_nxt.wave = 1'b0;
        end else if (count_tick) begin
            if (at_match) begin
                // Interval is match+1 count clocks: 1 to 256
                st_nxt.count = TEC_COUNT_RESET;
                st_nxt.irq = 1'b1;
                if (timer_owns_pin) begin
                    st_nxt.wave = ~st_r.wave;
                end
            end else begin
                st_nxt.count = 8'(st_r.count + 8'h01);
            end
        end

        if (wr_mode) begin
            st_nxt.mode = tec_mode_t'(mode_merged);
        end
        if (wr_dir) begin
            st_nxt.dir = dir_merged;
        end
        // Compared on the very next cycle, even while running
        if (wr_match) begin
            st_nxt.match = reg_req_in.wdata;
        end

        // Pin: output buffer on when direction bit is 0
        st_nxt.pin_oe = !st_r.dir[TEC_DIR_PIN_BIT];
        st_nxt.pin_o = timer_owns_pin ? st_r.wave : port_latch_in;

        if (reg_req_in.rd) begin
            st_nxt.rvalid = 1'b1;
            unique case (reg_req_in.addr)
                TEC_ADDR_COUNT: st_nxt.rdata = st_r.count;
                TEC_ADDR_MODE: st_nxt.rdata = mode_bits;
                TEC_ADDR_PORT5_DIR: st_nxt.rdata = st_r.dir;
                default: st_nxt.rdata = TEC_UNMAPPED_READ;
            endcase
        end

        if (!rst_b_in) begin
            st_nxt.mode = tec_mode_t'(TEC_MODE_RESET);
            st_nxt.dir = TEC_DIR_RESET;
            st_nxt.count = TEC_COUNT_RESET;
            st_nxt.match = st_r.match;
            st_nxt.prescale = TEC_PRESCALE_RESET;
            st_nxt.wave = 1'b0;
            st_nxt.irq = 1'b0;
            st_nxt.pin_o = 1'b0;
            st_nxt.pin_oe = 1'b0;
            st_nxt.rdata = 8'h00;
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        st_r <= st_nxt;
    end

    assign reg_rdata_out = st_r.rdata;
    assign reg_rvalid_out = st_r.rvalid;
    assign shared_pin_out = st_r.pin_o;
    assign shared_pin_oe_out = st_r.pin_oe;
    assign wave_out = st_r.wave;
    assign match_irq_out = st_r.irq;
    assign port5_direction_out = st_r.dir;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // Reset checks are the one place the default disable must not mask
    a_reset_values: assert property (
        disable iff (1'b0)
        !rst_b_in |=> (st_r.count == TEC_COUNT_RESET) && (st_r.mode == TEC_MODE_RESET)
            && (st_r.dir == TEC_DIR_RESET) && !match_irq_out && !shared_pin_oe_out)
        else $error("registers not at reset values after reset");

    a_match_keeps: assert property (
        disable iff (1'b0)
        (!rst_b_in && !wr_match) |=> (st_r.match === $past(st_r.match)))
        else $error("match value changed by reset");

    a_irq_cause: assert property (
        match_irq_out |-> $past(count_tick && at_match && st_r.mode.run))
        else $error("match request without a counted match");

    a_match_wraps: assert property (
        (count_tick && at_match) |=> (st_r.count == 8'h00) && match_irq_out)
        else $error("counter did not wrap with request on match");

    a_stop_zero: assert property (
        !st_r.mode.run |=> (st_r.count == 8'h00) && !wave_out && !match_irq_out)
        else $error("stopped counter not held at zero");

    a_fx_step: assert property (
        (st_r.mode.run && st_r.mode.sel == TEC_SEL_FX && !at_match)
        |=> (st_r.count == 8'($past(st_r.count) + 8'h01)))
        else $error("fx source did not count every clock");

    a_div32_hold: assert property (
        (st_r.mode.run && st_r.mode.sel == TEC_SEL_FX32 && st_r.prescale != PRESCALE_LAST)
        |=> $stable(st_r.count))
        else $error("fx/32 source counted early");

    a_edge_count: assert property (
        (st_r.mode.run && st_r.mode.sel == TEC_SEL_RISE && !at_match)
        |=> (st_r.count == 8'($past(st_r.count) + {7'h00, $past(ext_edges.rise)})))
        else $error("rising edge count mismatch");

    a_ext_no_wave: assert property (
        (st_r.mode.run && sel_ext) |=> $stable(wave_out))
        else $error("timer output toggled with external source");

    a_wave_toggle: assert property (
        (count_tick && at_match && timer_owns_pin) |=> (wave_out != $past(wave_out)))
        else $error("output did not invert on match");

    a_pin_buffer: assert property (
        $past(rst_b_in) |-> (shared_pin_oe_out == !$past(st_r.dir[TEC_DIR_PIN_BIT])))
        else $error("pin buffer does not follow direction bit");

    a_dir_upper: assert property (
        st_r.dir[7:4] == 4'hF)
        else $error("direction upper nibble not ones");

    a_match_write: assert property (
        wr_match |=> (st_r.match == $past(reg_req_in.wdata)))
        else $error("match value not stored");
endmodule
`default_nettype wire

/* verif/tec_pin_src.sv */
// Purpose: Pulse source and load on the shared timer pin.
// Assumes: The source drives only while the device leaves the pin as input.
// Notes: The wire level resolves the device drive against the source.
`timescale 1ns/100ps
`default_nettype none
module tec_pin_src (
    input wire logic src_lvl_in,
    input wire logic dev_oe_in,
    input wire logic dev_o_in,
    output logic pin_out
);
    import tec_pkg::*;
    // The device drive wins; otherwise the pulse source owns the line
    assign pin_out = dev_oe_in ? dev_o_in : src_lvl_in;
endmodule
`default_nettype wire

/* verif/tb_eight_bit_timer_event_counter.sv */
// Purpose: Self-checking bench for the 8-bit timer/event counter.
// Assumes: The bench plays the CPU; a pulse source sits on the shared pin.
// Notes: Register values are mirrored in the bench and compared at each read.
`timescale 1ns/100ps
`default_nettype none
module tb_eight_bit_timer_event_counter;
    import tec_pkg::*;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    tec_reg_req_t req = '0;
    logic src = 1'b0;
    logic latch = 1'b0;
    logic pin, pin_o, pin_oe, wave, irq, rvalid;
    logic [7:0] rdata, dir_o, mode_m, dir_m, m;
    int err_total = 0;
    int comparisons = 0;
    int seed = 32'hd6edc481;
    int g, n, sel;
    logic w0;

    tec_timer dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .shared_pin_in(pin), .port_latch_in(latch), .shared_pin_out(pin_o),
        .shared_pin_oe_out(pin_oe), .wave_out(wave), .match_irq_out(irq), .port5_direction_out(dir_o));
    tec_pin_src src_m (.src_lvl_in(src), .dev_oe_in(pin_oe), .dev_o_in(pin_o), .pin_out(pin));

    initial begin
        forever #25 clk_in = ~clk_in;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] k);
        @(posedge clk_in);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d, wmask: k};
        @(posedge clk_in);
        req.wr <= 1'b0;
        if (a == TEC_ADDR_MODE) mode_m = ((mode_m & ~k) | (d & k)) & TEC_MODE_WRITABLE;
        if (a == TEC_ADDR_PORT5_DIR) dir_m = (dir_m & ~k) | (d & k) | TEC_DIR_FIXED_ONES;
    endtask

    // Read answer stands exactly one clock after the strobe is taken
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_in);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00, wmask: 8'h00};
        @(posedge clk_in);
        req.rd <= 1'b0;
        #1;
        chk({15'h0, rvalid}, 16'h0001);
        chk({8'h00, rdata}, {8'h00, e});
    endtask

    // Cycles from one match request to the next, bounded
    task automatic irq_gap(output int gap);
        int c;
        c = 0;
        gap = 0;
        #1;
        while (irq !== 1'b1 && c < 2000) begin
            @(posedge clk_in);
            #1;
            c++;
        end
        do begin
            @(posedge clk_in);
            #1;
            gap++;
        end while (irq !== 1'b1 && gap < 2000);
    endtask

    // Widths of three or more keep edges apart for the synchroniser
    task automatic pulse(input int w);
        @(posedge clk_in);
        src <= 1'b1;
        repeat (w) @(posedge clk_in);
        src <= 1'b0;
        repeat (w) @(posedge clk_in);
    endtask

    task automatic end_sim;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        end_sim();
    end

    initial begin
        mode_m = TEC_MODE_RESET;
        dir_m = TEC_DIR_RESET;
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd_chk(TEC_ADDR_MODE, mode_m);
        rd_chk(TEC_ADDR_PORT5_DIR, dir_m);
        rd_chk(TEC_ADDR_COUNT, TEC_COUNT_RESET);
        rd_chk(16'hFF00, TEC_UNMAPPED_READ);
        wr(TEC_ADDR_PORT5_DIR, 8'h00, 8'hFF);
        rd_chk(TEC_ADDR_PORT5_DIR, dir_m);
        wr(TEC_ADDR_PORT5_DIR, 8'h01, 8'h01);
        rd_chk(TEC_ADDR_PORT5_DIR, dir_m);
        chk({8'h00, dir_o}, {8'h00, dir_m});
        $display("test registers done");
        for (sel = 0; sel < 2; sel++) begin
            m = 8'($random(seed)) & 8'h0F;
            wr(TEC_ADDR_MODE, 8'(sel << 1), 8'hFF);
            wr(TEC_ADDR_MATCH, m, 8'hFF);
            wr(TEC_ADDR_MODE, 8'h80 | 8'(sel << 1), 8'hFF);
            irq_gap(g);
            irq_gap(g);
            chk(16'(g), 16'((m + 1) * (sel == 1 ? TEC_PRESCALE_DIV : 1)));
            wr(TEC_ADDR_MODE, 8'h00, 8'hFF);
            rd_chk(TEC_ADDR_COUNT, 8'h00);
        end
        $display("test interval done");
        for (sel = 2; sel < 4; sel++) begin
            n = 3 + ($random(seed) & 3);
            wr(TEC_ADDR_MODE, 8'(sel << 1), 8'hFF);
            wr(TEC_ADDR_MATCH, 8'hFF, 8'hFF);
            wr(TEC_ADDR_MODE, 8'h81 | 8'(sel << 1), 8'hFF);
            repeat (n) pulse(3 + ($random(seed) & 3));
            repeat (6) @(posedge clk_in);
            rd_chk(TEC_ADDR_COUNT, 8'(n));
            chk({15'h0, wave}, 16'h0000);
            // Count already equals the new value, so the next valid edge must match
            wr(TEC_ADDR_MATCH, 8'(n), 8'hFF);
            @(posedge clk_in);
            src <= 1'b1;
            if (sel == 3) begin
                repeat (4) @(posedge clk_in);
                src <= 1'b0;
            end
            g = 0;
            while (irq !== 1'b1 && g < 8) begin
                @(posedge clk_in);
                #1;
                g++;
            end
            chk({15'h0, irq}, 16'h0001);
            chk({15'h0, wave}, 16'h0000);
            @(posedge clk_in);
            src <= 1'b0;
            rd_chk(TEC_ADDR_COUNT, 8'h00);
            wr(TEC_ADDR_MODE, 8'h00, 8'hFF);
        end
        $display("test events done");
        latch <= 1'b0;
        wr(TEC_ADDR_PORT5_DIR, 8'hFE, 8'hFF);
        wr(TEC_ADDR_MODE, 8'h01, 8'hFF);
        wr(TEC_ADDR_MATCH, 8'h03, 8'hFF);
        wr(TEC_ADDR_MODE, 8'h81, 8'hFF);
        irq_gap(g);
        w0 = wave;
        irq_gap(g);
        chk({15'h0, wave}, {15'h0, ~w0});
        chk(16'(g), 16'h0004);
        // Pin stage lags the wave by one clock
        @(posedge clk_in);
        #1;
        chk({14'h0, pin_oe, pin_o}, {14'h0, 1'b1, wave});
        wr(TEC_ADDR_MODE, 8'h01, 8'hFF);
        repeat (2) @(posedge clk_in);
        #1;
        chk({15'h0, wave}, 16'h0000);
        latch <= 1'b1;
        wr(TEC_ADDR_MODE, 8'h00, 8'hFF);
        repeat (2) @(posedge clk_in);
        #1;
        chk({15'h0, pin_o}, 16'h0001);
        rd_chk(TEC_ADDR_MODE, mode_m);
        $display("test square wave done");
        wr(TEC_ADDR_MATCH, 8'h05, 8'hFF);
        wr(TEC_ADDR_MODE, 8'h80, 8'hFF);
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        mode_m = TEC_MODE_RESET;
        dir_m = TEC_DIR_RESET;
        rd_chk(TEC_ADDR_MODE, mode_m);
        chk({8'h00, dir_o}, {8'h00, dir_m});
        rd_chk(TEC_ADDR_COUNT, TEC_COUNT_RESET);
        // Match value is not reset, so the old interval must return
        wr(TEC_ADDR_MODE, 8'h80, 8'hFF);
        irq_gap(g);
        irq_gap(g);
        chk(16'(g), 16'h0006);
        wr(TEC_ADDR_MODE, 8'h00, 8'hFF);
        $display("test reset done");
        end_sim();
    end
endmodule
`default_nettype wire
